// *** hdl/mlsc_pkg.sv ***
package mlsc_pkg;

    localparam int          LANES           = 4;
    localparam int          REG_COUNT       = 25;
    localparam int          REG_BITS        = 32;
    localparam int          SYNC_STAGES     = 2;
    localparam int          INSTR_BITS      = 8;

    // Instruction byte layout
    localparam int          INSTR_RW_POS    = 7;
    localparam int          INSTR_ADDR_MSB  = 4;

    // Channel select register layout and reset
    localparam logic [4:0]  CSR_ADDR        = 5'h00;
    localparam int          CSR_LSB_POS     = 0;
    localparam int          CSR_MODE_LSB    = 1;
    localparam int          CSR_CHEN_LSB    = 4;
    localparam logic [31:0] CSR_RESET       = 32'h0000_00f0;

    // Other registers with a known reset value
    localparam logic [4:0]  FR1_ADDR        = 5'h01;
    localparam logic [4:0]  CFR_ADDR        = 5'h03;
    localparam logic [31:0] CFR_RESET       = 32'h0000_0302;

    // Lane modes, as coded in the lane mode field
    typedef enum logic [1:0] {
        MODE_2WIRE = 2'b00,
        MODE_3WIRE = 2'b01,
        MODE_DUAL  = 2'b10,
        MODE_QUAD  = 2'b11
    } mlsc_lane_mode_t;

    typedef enum logic [1:0] {
        PH_INSTR,
        PH_WRITE,
        PH_READ
    } mlsc_phase_t;

    typedef struct packed {
        logic lane1_en;
        logic lane1_level;
        logic lane2_en;
        logic lane2_level;
    } mlsc_ramp_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] addr;
        logic [1:0] byte_idx;
        logic [7:0] data;
    } mlsc_wr_event_t;

    // Byte width of each register address; unmapped addresses take one byte
    function automatic logic [2:0] mlsc_reg_bytes(input logic [4:0] addr);
        logic [2:0] w;
        w = 3'h1;
        if (addr == 5'h00) begin
            w = 3'h1;
        end else if (addr == 5'h01 || addr == 5'h03 || addr == 5'h06) begin
            w = 3'h3;
        end else if (addr == 5'h02 || addr == 5'h05 || addr == 5'h07) begin
            w = 3'h2;
        end else if (addr <= 5'h18) begin
            w = 3'h4;
        end
        return w;
    endfunction

endpackage

// *** hdl/mlsc_sync.sv ***
`timescale 1ns/10ps
module mlsc_sync #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    if (WIDTH < 1) begin : g_check
        $error("mlsc_sync width must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } mlsc_sync_state_t;

    mlsc_sync_state_t s_q;
    mlsc_sync_state_t s_d;

    // Only the second stage is visible outside
    always_comb begin
        s_d        = s_q;
        s_d.meta   = i_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= {RESET_VALUE, RESET_VALUE};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.stable;

endmodule // mlsc_sync

// *** hdl/mlsc_port.sv ***
`timescale 1ns/10ps
module mlsc_port #(
    parameter int REG_COUNT = mlsc_pkg::REG_COUNT
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_rstn,
    input  wire logic                     i_sclk,
    input  wire logic                     i_port_select_n,
    input  wire logic [3:0]               i_lane,
    output logic      [3:0]               o_lane,
    output logic      [3:0]               o_lane_oe_n,
    output mlsc_pkg::mlsc_lane_mode_t     o_lane_mode_field,
    output logic                          o_lsb_first_bit,
    output logic      [3:0]               o_channel_enable,
    output logic      [23:0]              o_function_reg_one,
    output mlsc_pkg::mlsc_ramp_t          o_amplitude_ramp_ctrl,
    output mlsc_pkg::mlsc_wr_event_t      o_wr_event,
    output logic                          o_resync_abort,
    output logic                          o_cycle_active
);

    if (REG_COUNT < 4 || REG_COUNT > mlsc_pkg::REG_COUNT) begin : g_check
        $error("mlsc_port register count out of range");
    end

    localparam logic [5:0] SYNC_RESET = 6'b000010;

    typedef struct packed {
        logic                           sclk_prev;
        mlsc_pkg::mlsc_phase_t          phase;
        logic [5:0]                     cnt;
        logic [4:0]                     addr;
        logic [31:0]                    shift;
        logic                           launched;
        logic [3:0]                     lane_out;
        logic [3:0]                     lane_oe_n;
        logic                           resync;
        mlsc_pkg::mlsc_ramp_t           ramp;
        mlsc_pkg::mlsc_wr_event_t       wr;
        logic [REG_COUNT-1:0][31:0]     regs;
    } mlsc_port_state_t;

    mlsc_port_state_t s_q;
    mlsc_port_state_t s_d;

    logic [5:0] pins_sync;

    // Every pin crosses from the host's timing into ours
    mlsc_sync #(
        .WIDTH       (6),
        .RESET_VALUE (SYNC_RESET)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_lane, i_port_select_n, i_sclk}),
        .o_sync  (pins_sync)
    );

    logic                       sclk;
    logic                       sel_n;
    logic [3:0]                 lanes;
    logic                       rise;
    logic                       fall;
    mlsc_pkg::mlsc_lane_mode_t  mode;
    logic                       lsb;
    logic [2:0]                 bpc;
    logic [5:0]                 nbits;
    logic [5:0]                 base;
    logic [5:0]                 cnt_next;
    logic                       last;
    logic                       resync_now;
    logic [3:0]                 drive_mask;
    logic [31:0]                rd_word;
    logic                       addr_ok;
    logic [1:0]                 byte_idx;

    always_comb begin
        sclk  = pins_sync[0];
        sel_n = pins_sync[1];
        lanes = pins_sync[5:2];
        // Edges come from the sampled clock, so a stall simply yields no edge
        rise  = sclk & ~s_q.sclk_prev;
        fall  = ~sclk & s_q.sclk_prev;
        mode  = mlsc_pkg::mlsc_lane_mode_t'(s_q.regs[0][mlsc_pkg::CSR_MODE_LSB +: 2]);
        lsb   = s_q.regs[0][mlsc_pkg::CSR_LSB_POS];
    end

    // Bits per clock and lanes driven while reading
    always_comb begin
        bpc        = 3'h1;
        drive_mask = 4'h1;
        case (mode)
            mlsc_pkg::MODE_2WIRE: begin
                bpc        = 3'h1;
                drive_mask = 4'h1;
            end
            mlsc_pkg::MODE_3WIRE: begin
                bpc        = 3'h1;
                drive_mask = 4'h4;
            end
            mlsc_pkg::MODE_DUAL: begin
                bpc        = 3'h2;
                drive_mask = 4'h3;
            end
            mlsc_pkg::MODE_QUAD: begin
                bpc        = 3'h4;
                drive_mask = 4'hf;
            end
            default: begin
                bpc        = 3'h1;
                drive_mask = 4'h1;
            end
        endcase
    end

    always_comb begin
        addr_ok = (s_q.addr < 5'(REG_COUNT));
        rd_word = addr_ok ? s_q.regs[s_q.addr] : 32'h0000_0000;
        if (s_q.phase == mlsc_pkg::PH_INSTR) begin
            nbits = 6'(mlsc_pkg::INSTR_BITS);
        end else begin
            nbits = {mlsc_pkg::mlsc_reg_bytes(s_q.addr), 3'b000};
        end
        cnt_next = 6'(s_q.cnt + {3'b000, bpc});
        last     = (cnt_next == nbits);
        // Position of lane 0's bit in the word for the current clock
        if (lsb) begin
            base = s_q.cnt;
        end else begin
            base = 6'(nbits - {3'b000, bpc} - s_q.cnt);
        end
        byte_idx   = base[4:3];
        // In quad mode lane 3 is data and must not abort
        resync_now = lanes[3] && (mode != mlsc_pkg::MODE_QUAD);
    end

    always_comb begin
        s_d           = s_q;
        s_d.sclk_prev = sclk;
        s_d.wr.valid  = 1'b0;
        s_d.resync    = resync_now;

        // Ramp inputs only exist on lanes the mode leaves free
        s_d.ramp.lane1_en    = (mode == mlsc_pkg::MODE_2WIRE) || (mode == mlsc_pkg::MODE_3WIRE);
        s_d.ramp.lane1_level = s_d.ramp.lane1_en & lanes[1];
        s_d.ramp.lane2_en    = (mode == mlsc_pkg::MODE_2WIRE) || (mode == mlsc_pkg::MODE_DUAL);
        s_d.ramp.lane2_level = s_d.ramp.lane2_en & lanes[2];

        if (resync_now) begin
            // Held in the idle state as long as the level stays high
            s_d.phase    = mlsc_pkg::PH_INSTR;
            s_d.cnt      = 6'h00;
            s_d.launched = 1'b0;
        end else if (sel_n) begin
            // Position is kept, so the cycle picks up where it left off
            s_d.launched = s_q.launched;
        end else begin
            if (rise) begin
                for (int j = 0; j < mlsc_pkg::LANES; j++) begin
                    if (j < int'(bpc)) begin
                        // Lane j always carries bit j of the group
                        s_d.shift[5'(base + 6'(j))] = lanes[j];
                    end
                end
                s_d.cnt = cnt_next;
                case (s_q.phase)
                    mlsc_pkg::PH_INSTR: begin
                        if (last) begin
                            s_d.addr     = s_d.shift[mlsc_pkg::INSTR_ADDR_MSB:0];
                            s_d.cnt      = 6'h00;
                            s_d.launched = 1'b0;
                            if (s_d.shift[mlsc_pkg::INSTR_RW_POS]) begin
                                s_d.phase = mlsc_pkg::PH_READ;
                            end else begin
                                s_d.phase = mlsc_pkg::PH_WRITE;
                            end
                        end
                    end
                    mlsc_pkg::PH_WRITE: begin
                        // Bytes commit one by one, so an abort keeps whole bytes only
                        if (cnt_next[2:0] == 3'h0) begin
                            if (addr_ok) begin
                                s_d.regs[s_q.addr][{byte_idx, 3'b000} +: 8] =
                                    s_d.shift[{byte_idx, 3'b000} +: 8];
                            end
                            s_d.wr.valid    = 1'b1;
                            s_d.wr.addr     = s_q.addr;
                            s_d.wr.byte_idx = byte_idx;
                            s_d.wr.data     = s_d.shift[{byte_idx, 3'b000} +: 8];
                        end
                        if (last) begin
                            s_d.phase = mlsc_pkg::PH_INSTR;
                            s_d.cnt   = 6'h00;
                        end
                    end
                    mlsc_pkg::PH_READ: begin
                        if (last) begin
                            s_d.phase    = mlsc_pkg::PH_INSTR;
                            s_d.cnt      = 6'h00;
                            s_d.launched = 1'b0;
                        end
                    end
                    default: begin
                        s_d.phase = mlsc_pkg::PH_INSTR;
                        s_d.cnt   = 6'h00;
                    end
                endcase
            end else if (fall && (s_q.phase == mlsc_pkg::PH_READ)) begin
                // Launch on the falling edge; the host samples at the next rise
                s_d.launched = 1'b1;
                if (mode == mlsc_pkg::MODE_3WIRE) begin
                    s_d.lane_out[2] = rd_word[5'(base)];
                end else begin
                    for (int j = 0; j < mlsc_pkg::LANES; j++) begin
                        if (j < int'(bpc)) begin
                            s_d.lane_out[j] = rd_word[5'(base + 6'(j))];
                        end
                    end
                end
            end
        end

        // Lanes are released when not reading, deselected or aborting
        if ((s_d.phase == mlsc_pkg::PH_READ) && s_d.launched && !sel_n && !resync_now) begin
            s_d.lane_oe_n = ~drive_mask;
        end else begin
            s_d.lane_oe_n = 4'hf;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q           <= '0;
            s_q.sclk_prev <= 1'b0;
            s_q.phase     <= mlsc_pkg::PH_INSTR;
            s_q.lane_oe_n <= 4'hf;
            s_q.regs[0]   <= mlsc_pkg::CSR_RESET;
            s_q.regs[3]   <= mlsc_pkg::CFR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_lane                = s_q.lane_out;
    assign o_lane_oe_n           = s_q.lane_oe_n;
    assign o_lane_mode_field     = mlsc_pkg::mlsc_lane_mode_t'(s_q.regs[0][mlsc_pkg::CSR_MODE_LSB +: 2]);
    assign o_lsb_first_bit       = s_q.regs[0][mlsc_pkg::CSR_LSB_POS];
    assign o_channel_enable      = s_q.regs[0][mlsc_pkg::CSR_CHEN_LSB +: 4];
    assign o_function_reg_one    = s_q.regs[1][23:0];
    assign o_amplitude_ramp_ctrl = s_q.ramp;
    assign o_wr_event            = s_q.wr;
    assign o_resync_abort        = s_q.resync;
    assign o_cycle_active        = (s_q.phase != mlsc_pkg::PH_INSTR) || (s_q.cnt != 6'h00);

endmodule // mlsc_port

// *** verification/mlsc_port_assertions.sv ***
`timescale 1ns/10ps
module mlsc_port_checker (
    input wire logic                      i_clock,
    input wire logic                      i_rstn,
    input wire logic                      i_port_select_n,
    input wire logic [3:0]                i_lane,
    input wire logic [3:0]                o_lane_oe_n,
    input wire mlsc_pkg::mlsc_lane_mode_t o_lane_mode_field,
    input wire mlsc_pkg::mlsc_ramp_t      o_amplitude_ramp_ctrl,
    input wire mlsc_pkg::mlsc_wr_event_t  o_wr_event,
    input wire logic                      o_resync_abort
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    // Pins pass two sync flops and an output register, so allow four edges
    select_release_a: assert property (i_port_select_n [*5] |-> o_lane_oe_n == 4'hf)
        else $error("lanes driven while deselected");
    resync_on_a: assert property ((i_lane[3] && o_lane_mode_field != mlsc_pkg::MODE_QUAD) [*5]
        |-> o_resync_abort) else $error("resync level not seen");
    quad_no_resync_a: assert property (o_lane_mode_field == mlsc_pkg::MODE_QUAD [*2]
        |-> !o_resync_abort) else $error("resync active in quad mode");
    resync_release_a: assert property (o_resync_abort [*3] |-> o_lane_oe_n == 4'hf)
        else $error("lanes driven during resync");
    two_wire_a: assert property (o_lane_mode_field == mlsc_pkg::MODE_2WIRE
        |-> o_lane_oe_n[3:1] == 3'b111) else $error("two-wire drives extra lane");
    three_wire_a: assert property (o_lane_mode_field == mlsc_pkg::MODE_3WIRE
        |-> o_lane_oe_n[0] && o_lane_oe_n[1] && o_lane_oe_n[3]) else $error("three-wire drives wrong lane");
    // Enables lag the mode by one edge, so the mode must have held for two
    ramp_enable_a: assert property ($stable(o_lane_mode_field) [*2]
        |-> o_amplitude_ramp_ctrl.lane1_en == !o_lane_mode_field[1]
            && o_amplitude_ramp_ctrl.lane2_en == !o_lane_mode_field[0]) else $error("ramp enable wrong");
    byte_spacing_a: assert property (o_wr_event.valid |=> !o_wr_event.valid [*8])
        else $error("byte events too close");
endmodule // mlsc_port_checker

// *** verification/mlsc_host.sv ***
`timescale 1ns/10ps
module mlsc_host (
    input  wire logic       i_clock,
    input  wire logic [3:0] i_wire,
    output logic            o_sclk,
    output logic            o_select_n,
    output logic [3:0]      o_lane,
    output logic [3:0]      o_drive
);
    initial begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_lane = 4'h0;
        o_drive = 4'hf;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // One access; st stalls after that clock's rise and before its fall, ab aborts before it (-1 for none)
    task automatic xfer(input logic [1:0] md, input logic lf, input logic [7:0] ins, input logic [31:0] wd,
                        input int nb, input int st, input int ab, output logic [31:0] rd);
        int bpc, ni, n, w, idx, j, k;
        logic [31:0] v;
        logic [3:0] dm;
        bpc = md == 2'b11 ? 4 : md == 2'b10 ? 2 : 1;
        ni = 8 / bpc;
        n = ni + nb * 8 / bpc;
        dm = md == 2'b01 ? 4'b1011 : 4'hf;
        rd = '0;
        o_drive <= dm;
        o_select_n <= 1'b0;
        tick(6);
        for (k = 0; k < n; k++) begin
            if (k == ab) begin
                o_lane[3] <= 1'b1;
                tick(12);
                o_lane[3] <= 1'b0;
                break;
            end
            w = k < ni ? ni : n - ni;
            idx = lf ? (k < ni ? k : k - ni) : w - 1 - (k < ni ? k : k - ni);
            v = k < ni ? {24'h0, ins} : wd;
            // Lane 3 stays low outside quad instruction and write bits, also while entering quad
            if (k < ni || !ins[7]) for (j = 0; j < 4; j++) o_lane[j] <= j < bpc ? v[idx*bpc+j] : 1'b0;
            tick(6);
            o_sclk <= 1'b1;
            if (k >= ni && ins[7]) for (j = 0; j < bpc; j++) rd[idx*bpc+j] = i_wire[j+(md == 2'b01 ? 2 : 0)];
            tick(6);
            if (k == st) begin
                o_select_n <= 1'b1;
                tick(30);
                o_select_n <= 1'b0;
                tick(6);
            end
            o_sclk <= 1'b0;
            if (k == ni - 1 && ins[7] && md != 2'b01) o_drive <= dm & ~4'((1 << bpc) - 1);
        end
        tick(6);
        o_drive <= dm;
        o_lane <= 4'h0;
        o_select_n <= 1'b1;
        tick(12);
    endtask
endmodule // mlsc_host

// *** verification/mlsc_port_test.sv ***
`timescale 1ns/10ps
module mlsc_port_test;
    logic                      clk, rstn, sclk, sel_n, lsb_o, lf, cyc;
    logic [3:0]                d_lane, d_oe_n, h_lane, h_drive, lane_w, chen;
    logic [23:0]               fr1;
    logic [1:0]                md;
    logic [31:0]               seed;
    mlsc_pkg::mlsc_lane_mode_t mode;
    mlsc_pkg::mlsc_ramp_t      ramp;
    mlsc_pkg::mlsc_wr_event_t  ev;
    mlsc_pkg::mlsc_wr_event_t  last_ev = '0;
    int                        miscompares = 0;
    int                        comparisons = 0;

    // A released lane reads back the inverse of its last level
    assign lane_w = (~d_oe_n & d_lane) | (d_oe_n & ~(h_drive ^ h_lane));

    mlsc_port u_dut (
        .i_clock               (clk),
        .i_rstn                (rstn),
        .i_sclk                (sclk),
        .i_port_select_n       (sel_n),
        .i_lane                (lane_w),
        .o_lane                (d_lane),
        .o_lane_oe_n           (d_oe_n),
        .o_lane_mode_field     (mode),
        .o_lsb_first_bit       (lsb_o),
        .o_channel_enable      (chen),
        .o_function_reg_one    (fr1),
        .o_amplitude_ramp_ctrl (ramp),
        .o_wr_event            (ev),
        .o_resync_abort        (),
        .o_cycle_active        (cyc)
    );

    mlsc_host u_host (
        .i_clock    (clk),
        .i_wire     (lane_w),
        .o_sclk     (sclk),
        .o_select_n (sel_n),
        .o_lane     (h_lane),
        .o_drive    (h_drive)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) if (ev.valid === 1'b1) last_ev <= ev;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        stop_test;
    end

    initial begin
        logic [31:0] r, w, w2, rd;
        logic [1:0] m;
        logic l;
        rstn = 1'b0;
        md = 2'b00;
        lf = 1'b0;
        seed = 32'h921a9a4a;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        // Kept in two words so the mode bits are not cut off
        cmp(32'({mode, lsb_o, chen, d_oe_n}), 32'({2'b00, 1'b0, 4'hf, 4'hf}));
        cmp(32'({cyc, fr1}), 32'h0);
        u_host.xfer(md, lf, 8'h83, 32'h0, 3, -1, -1, rd);
        cmp(rd, mlsc_pkg::CFR_RESET);
        // Every mode in both orders, then random mode hops
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            m = i < 8 ? i[1:0] : r[9:8];
            l = i < 8 ? i[2] : r[10];
            u_host.xfer(md, lf, {1'b0, r[12:11], 5'h00}, {24'h0, r[3:0], 1'b0, m, l}, 1, -1, -1, rd);
            md = m;
            lf = l;
            cmp(32'({mode, lsb_o, chen}), 32'({m, l, r[3:0]}));
            cmp(32'({ramp.lane1_en, ramp.lane2_en}), 32'({~m[1], ~m[0]}));
            w = rnd() & 32'h00ff_ffff;
            u_host.xfer(md, lf, 8'h01, w, 3, -1, -1, rd);
            cmp(32'(fr1), w);
            // The byte that closes the cycle depends on the order
            cmp(32'(last_ev), lf ? 32'({1'b1, 5'h01, 2'h2, w[23:16]}) : 32'({1'b1, 5'h01, 2'h0, w[7:0]}));
            u_host.xfer(md, lf, 8'h81, 32'h0, 3, -1, -1, rd);
            cmp(rd, w);
            w = rnd();
            u_host.xfer(md, lf, 8'(8 + i), w, 4, -1, -1, rd);
            u_host.xfer(md, lf, {1'b1, r[14:13], 5'(8 + i)}, 32'h0, 4, -1, -1, rd);
            cmp(rd, w);
            $display("test %0d done", i);
        end
        u_host.xfer(md, lf, 8'h00, 32'hf0, 1, -1, -1, rd);
        md = 2'b00;
        lf = 1'b0;
        w = rnd() & 32'h00ff_ffff;
        u_host.xfer(md, lf, 8'h01, w, 3, 12, -1, rd);
        cmp(32'(fr1), w);
        $display("test stall done");
        // Abort three bits into the second data byte: only the first byte lands
        w2 = rnd();
        u_host.xfer(md, lf, 8'h01, w2, 3, -1, 19, rd);
        cmp(32'(fr1), {8'h0, w2[23:16], w[15:0]});
        u_host.xfer(md, lf, 8'h81, 32'h0, 3, -1, -1, rd);
        cmp(rd, {8'h0, w2[23:16], w[15:0]});
        cmp(32'(cyc), 32'h0);
        u_host.xfer(md, lf, 8'h1f, rnd(), 1, -1, -1, rd);
        u_host.xfer(md, lf, 8'h9f, 32'h0, 1, -1, -1, rd);
        cmp(rd, 32'h0);
        $display("test abort done");
        stop_test;
    end
endmodule // mlsc_port_test

bind mlsc_port mlsc_port_checker u_chk (
    .i_clock               (i_clock),
    .i_rstn                (i_rstn),
    .i_port_select_n       (i_port_select_n),
    .i_lane                (i_lane),
    .o_lane_oe_n           (o_lane_oe_n),
    .o_lane_mode_field     (o_lane_mode_field),
    .o_amplitude_ramp_ctrl (o_amplitude_ramp_ctrl),
    .o_wr_event            (o_wr_event),
    .o_resync_abort        (o_resync_abort)
);
